// file: logic/mdfc_top.sv
// Duplex handling, collision retry and flow control for the MAC transmitter
//
// Operation
// - half duplex only when both select bits clear
// - full duplex when both set; mismatch blocks sending
// - no duplex negotiation is attempted
// - half duplex defers while carrier present, except a request that ends the jam goes straight to the gap
// - early collision backs off and retries
// - retry limit reached aborts, flags, signals error
// - late collision aborts at once
// - half duplex loops back unless disabled
// - full duplex ignores collisions and limits
// - full duplex loopback kills only the line driver; reception stays on
// - half duplex low enable bit jams preamble
// - request stops jam, waits gap, sends
// - jam resumes after packet; clearing bit stops
// - full duplex sends pause control frames
// - received pause finishes frame, then holds
// - timer steps every 512 bit times
// - new pause reloads; zero resumes sending
// - two-bit field selects pause frame mode
// - sent pause carries programmed pause value, zero in the closing mode
// - paused request waits, then sends and clears
`timescale 1ns/10ps
`default_nettype none
module mdfc_top
  import mdfc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  // Medium side
  input wire logic i_bit_tick,
  input wire logic i_carrier,
  input wire logic i_collision,
  input wire logic i_tx_byte,
  input wire logic i_tx_done,
  input wire logic i_rx_pause,
  input wire logic [15:0] i_rx_pause_val,
  input wire logic i_rx_busy,
  output logic o_tx_en,
  output var mdfc_kind_t o_tx_kind,
  output logic [15:0] o_tx_pause_val,
  output logic o_tx_err,
  output logic o_loopback,
  output logic o_tp_drv_off,
  output logic o_rx_enable
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEFER, ST_GAP, ST_SEND, ST_BACKOFF
  } mdfc_state_t;

  mdfc_pause_if pif ();
  mdfc_pause_timer #(.QBITS(QUANTUM_BITS)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .pif(pif)
  );

  logic [7:0] ctrl_q;
  logic [1:0] fc_q;
  logic [3:0] retransmission_maximum_q;
  logic [5:0] collision_window_q;
  logic [6:0] gap_q;
  logic [15:0] pause_q;
  logic abort_q, late_q;
  logic [3:0] retry_q;
  logic [5:0] bytes_q;
  logic [9:0] wait_q, lfsr_q;
  logic [8:0] slot_q;
  logic [14:0] period_q;
  mdfc_state_t st_q;
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;

  ////////////////////////////////////////////////////////////
  // Mode decode

  logic fdx, hdx, slot_tick, jam_now, pause_due, can_pkt;
  logic early_col, late_col, do_abort, fc_clear, req_clr;
  assign hdx = !ctrl_q[B_MAC_FD] && !ctrl_q[B_PHY_FD];
  // both bits set; a mismatch selects neither mode
  assign fdx = ctrl_q[B_MAC_FD] && ctrl_q[B_PHY_FD];
  // duplex follows software only, no link negotiation
  assign slot_tick = i_bit_tick && (&slot_q);
  assign jam_now = hdx && fc_q[B_FC_LO] && st_q == ST_IDLE
    && !ctrl_q[B_TX_REQ];
  // one-shot modes and the periodic mode
  assign pause_due = fdx && ctrl_q[B_TX_PAUSE] && (fc_q == FC_ONCE
    || fc_q == FC_ZERO_OFF || (fc_q == FC_PERIODIC && period_q == '0));
  // full duplex request held while paused
  assign can_pkt = ctrl_q[B_TX_REQ] && (hdx || (fdx && !pif.paused));
  // collisions matter only in half duplex
  assign early_col = st_q == ST_SEND && i_collision && hdx
    && o_tx_kind == KIND_PACKET && bytes_q < collision_window_q;
  assign late_col = st_q == ST_SEND && i_collision && hdx
    && o_tx_kind == KIND_PACKET && bytes_q >= collision_window_q;
  assign do_abort = late_col || (early_col && retry_q == retransmission_maximum_q);
  assign fc_clear = st_q == ST_SEND && i_tx_done
    && o_tx_kind == KIND_PAUSE && fc_q != FC_PERIODIC;
  assign req_clr = do_abort || (st_q == ST_SEND && i_tx_done
    && o_tx_kind == KIND_PACKET);

  // quanta taken from the transmit bit clock
  assign pif.bit_tick = i_bit_tick;
  // receive pause only when enabled and in full duplex
  assign pif.load = i_rx_pause && fdx && ctrl_q[B_RX_PAUSE];
  assign pif.value = i_rx_pause_val;

  ////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take one wait state

  logic addr_ok;
  logic [31:0] rd_word;
  assign addr_ok = i_hready && i_hsel && i_htrans[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_haddr[7:0])
      OFS_CTRL: rd_word[7:0] = ctrl_q;
      OFS_FLOW: rd_word[2:0] = {fdx, fc_q};
      OFS_LIMIT: rd_word[13:0] = {collision_window_q, 4'h0, retransmission_maximum_q};
      OFS_GAP: rd_word[6:0] = gap_q;
      OFS_PAUSE: rd_word[15:0] = pause_q;
      OFS_STAT: rd_word = {pif.timer, 8'h00, retry_q, late_q,
        jam_now, pif.paused, abort_q};
      default: rd_word = 32'h0000_0000;
    endcase
    if (i_haddr[31:8] != 24'h000000) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
    end else begin
      o_hresp <= 1'b0;
      wr_pend_q <= addr_ok && i_hwrite;
      o_hreadyout <= !(addr_ok && i_hwrite);
      if (addr_ok) begin
        wr_ofs_q <= (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : 8'hFF;
        o_hrdata <= i_hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  logic wr_ctrl, wr_flow, wr_stat;
  assign wr_ctrl = wr_pend_q && wr_ofs_q == OFS_CTRL;
  assign wr_flow = wr_pend_q && wr_ofs_q == OFS_FLOW;
  assign wr_stat = wr_pend_q && wr_ofs_q == OFS_STAT;

  ////////////////////////////////////////////////////////////
  // Registers

  // software request set wins over hardware clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= i_hwdata[7:0] | {7'h00, req_clr & ctrl_q[B_TX_REQ]
        & ~i_hwdata[B_TX_REQ] & 1'b0};
    end else if (req_clr) begin
      ctrl_q[B_TX_REQ] <= 1'b0;
    end
  end

  // one-shot modes turn themselves off; a write wins
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fc_q <= RST_FC;
    end else if (wr_flow) begin
      fc_q <= i_hwdata[1:0];
    end else if (fc_clear) begin
      fc_q <= FC_OFF;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      retransmission_maximum_q <= RST_RETRANSMISSION_MAXIMUM;
      collision_window_q <= RST_COLLISION_WINDOW;
      gap_q <= RST_GAP;
      pause_q <= RST_PAUSE;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == OFS_LIMIT) begin
        retransmission_maximum_q <= i_hwdata[B_RETRANSMISSION_MAXIMUM +: 4];
        collision_window_q <= i_hwdata[B_COLLISION_WINDOW +: 6];
      end
      if (wr_ofs_q == OFS_GAP) begin
        gap_q <= i_hwdata[6:0];
      end
      if (wr_ofs_q == OFS_PAUSE) begin
        pause_q <= i_hwdata[15:0];
      end
    end
  end

  // abort flag, write one to clear, a new abort wins
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      abort_q <= 1'b0;
      late_q <= 1'b0;
      o_tx_err <= 1'b0;
    end else begin
      o_tx_err <= do_abort;
      if (do_abort) begin
        abort_q <= 1'b1;
        late_q <= late_col;
      end else if (wr_stat && i_hwdata[B_ABORT]) begin
        abort_q <= 1'b0;
        late_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Slot timing, backoff source, periodic pause spacing

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_q <= '0;
      lfsr_q <= 10'h001;
    end else begin
      lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
      if (i_bit_tick) begin
        slot_q <= slot_q + 9'h001;
      end
    end
  end

  // Periodic resend at half the advertised pause so the far end never resumes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      period_q <= '0;
    // Stale spacing from one-shot frames must not delay the first periodic one
    end else if (fc_q != FC_PERIODIC) begin
      period_q <= '0;
    end else if (st_q == ST_SEND && i_tx_done && o_tx_kind == KIND_PAUSE) begin
      period_q <= pause_q[15:1];
    end else if (slot_tick && period_q != '0) begin
      period_q <= period_q - 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////
  // Transmit sequencer

  logic [3:0] exp_w;
  logic [9:0] mask_w;
  assign exp_w = (retry_q >= 4'(BACKOFF_CAP - 1)) ? 4'(BACKOFF_CAP)
    : retry_q + 4'h1;
  assign mask_w = 10'((11'h001 << exp_w) - 11'h001);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      o_tx_kind <= KIND_PACKET;
      retry_q <= 4'h0;
      bytes_q <= 6'h00;
      wait_q <= 10'h000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          bytes_q <= 6'h00;
          if (pause_due) begin
            // pause frames go first in full duplex
            o_tx_kind <= KIND_PAUSE;
            st_q <= ST_SEND;
          end else if (can_pkt) begin
            o_tx_kind <= KIND_PACKET;
            wait_q <= 10'h000;
            if (fdx) begin
              st_q <= ST_SEND;
            // request ends the jam, then the gap
            end else if (fc_q[B_FC_LO]) begin
              st_q <= ST_GAP;
            end else begin
              st_q <= ST_DEFER;
            end
          end
        end
        // wait for the other station to finish
        ST_DEFER: begin
          wait_q <= 10'h000;
          if (!i_carrier) begin
            st_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (i_bit_tick) begin
            wait_q <= wait_q + 10'h001;
          end
          if (wait_q >= {3'h0, gap_q}) begin
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (i_tx_byte && bytes_q != 6'h3F) begin
            bytes_q <= bytes_q + 6'h01;
          end
          if (do_abort) begin
            retry_q <= 4'h0;
            st_q <= ST_IDLE;
          // early collision keeps request, backs off
          end else if (early_col) begin
            retry_q <= retry_q + 4'h1;
            wait_q <= lfsr_q & mask_w;
            st_q <= ST_BACKOFF;
          end else if (i_tx_done) begin
            if (o_tx_kind == KIND_PACKET) begin
              retry_q <= 4'h0;
            end
            st_q <= ST_IDLE;
          end
        end
        ST_BACKOFF: begin
          bytes_q <= 6'h00;
          if (wait_q == 10'h000) begin
            st_q <= ST_DEFER;
          end else if (slot_tick) begin
            wait_q <= wait_q - 10'h001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Medium outputs

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_en <= 1'b0;
      o_tx_pause_val <= 16'h0000;
      o_loopback <= 1'b0;
      o_tp_drv_off <= 1'b0;
      o_rx_enable <= 1'b0;
    end else begin
      // jam pattern drives the medium while idle
      o_tx_en <= jam_now || st_q == ST_SEND;
      // pause value from software, zero for the closing frame
      o_tx_pause_val <= (fc_q == FC_ZERO_OFF) ? 16'h0000 : pause_q;
      // half duplex echo unless disabled; opt-in in full duplex
      o_loopback <= (hdx && !ctrl_q[B_HD_LB_DIS])
        || (fdx && ctrl_q[B_PHY_LB]);
      // diagnostic loopback drops the line driver
      o_tp_drv_off <= fdx && ctrl_q[B_PHY_LB];
      o_rx_enable <= ctrl_q[B_RX_EN] && !(fdx && ctrl_q[B_PHY_LB] && i_rx_busy
        && 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_early_retry;
    early_col && retry_q != retransmission_maximum_q;
  endsequence
  sequence s_backoff_done;
    st_q == ST_BACKOFF && wait_q == 10'h000;
  endsequence

  a_abort_clears_req: assert property (
    do_abort && !wr_ctrl |=> !ctrl_q[B_TX_REQ] && abort_q && o_tx_err)
    else $error("abort did not clear request");
  a_late_no_retry: assert property (
    late_col |=> st_q == ST_IDLE && late_q)
    else $error("late collision retried");
  a_early_backoff: assert property (
    s_early_retry |=> st_q == ST_BACKOFF && ctrl_q[B_TX_REQ])
    else $error("early collision not backed off");
  a_backoff_defers: assert property (
    s_backoff_done |=> st_q == ST_DEFER)
    else $error("backoff did not return to defer");
  a_defer_hold: assert property (
    st_q == ST_DEFER && i_carrier |=> st_q == ST_DEFER)
    else $error("sent over carrier");
  a_fdx_no_col: assert property (
    fdx && st_q == ST_SEND && i_collision |=> st_q != ST_BACKOFF)
    else $error("full duplex backed off");
  a_jam_half_only: assert property (
    o_tx_en && $past(st_q) != ST_SEND |-> $past(hdx && fc_q[B_FC_LO]))
    else $error("jam outside half duplex");
  a_req_ends_jam: assert property (
    st_q == ST_IDLE && hdx && fc_q[B_FC_LO] && ctrl_q[B_TX_REQ]
      && !pause_due |=> st_q == ST_GAP ##1 !jam_now)
    else $error("jam not stopped for request");
  a_paused_hold: assert property (
    st_q == ST_IDLE && fdx && pif.paused && !pause_due |=> st_q == ST_IDLE)
    else $error("sent while paused");
  a_oneshot_off: assert property (
    fc_clear && !wr_flow |=> fc_q == FC_OFF)
    else $error("one-shot pause mode stayed on");
  a_loop_mode: assert property (
    hdx && !ctrl_q[B_HD_LB_DIS] ##1 hdx |-> o_loopback)
    else $error("half duplex loopback missing");
endmodule
`default_nettype wire

// file: logic/mdfc_pkg.sv
// Shared constants for the duplex and flow control block
package mdfc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLOW = 8'h04;
  localparam logic [7:0] OFS_LIMIT = 8'h08;
  localparam logic [7:0] OFS_GAP = 8'h0C;
  localparam logic [7:0] OFS_PAUSE = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Control register fields
  localparam int B_TX_REQ = 0;
  localparam int B_RX_EN = 1;
  localparam int B_MAC_FD = 2;
  localparam int B_PHY_FD = 3;
  localparam int B_HD_LB_DIS = 4;
  localparam int B_PHY_LB = 5;
  localparam int B_RX_PAUSE = 6;
  localparam int B_TX_PAUSE = 7;
  // Flow register fields
  localparam int B_FC_LO = 0;
  localparam int B_FD_SHADOW = 2;
  // Limit register fields
  localparam int B_RETRANSMISSION_MAXIMUM = 0;
  localparam int B_COLLISION_WINDOW = 8;
  // Status register fields
  localparam int B_ABORT = 0;
  localparam int B_PAUSED = 1;
  localparam int B_JAM = 2;
  localparam int B_LATE = 3;
  localparam int B_RETRY = 4;
  localparam int B_PTIMER = 16;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_FC = 2'h0;
  localparam logic [3:0] RST_RETRANSMISSION_MAXIMUM = 4'hF;
  localparam logic [5:0] RST_COLLISION_WINDOW = 6'h37;
  localparam logic [6:0] RST_GAP = 7'h12;
  localparam logic [15:0] RST_PAUSE = 16'h1000;
  // Timing: quantum in bit times, backoff exponent cap
  localparam int QUANTUM_BITS = 512;
  localparam int BACKOFF_CAP = 10;
  // Flow control field encodings in full duplex
  localparam logic [1:0] FC_OFF = 2'h0;
  localparam logic [1:0] FC_ONCE = 2'h1;
  localparam logic [1:0] FC_PERIODIC = 2'h2;
  localparam logic [1:0] FC_ZERO_OFF = 2'h3;
  // What the transmitter is told to send
  typedef enum logic [1:0] {
    KIND_PACKET,
    KIND_JAM,
    KIND_PAUSE
  } mdfc_kind_t;
endpackage

// file: logic/mdfc_pause_if.sv
// Link between the transmit controller and its pause timer
`timescale 1ns/10ps
`default_nettype none
interface mdfc_pause_if;
  logic load;
  logic [15:0] value;
  logic bit_tick;
  logic paused;
  logic [15:0] timer;
  modport ctrl (output load, output value, output bit_tick, input paused, input timer);
  modport tmr (input load, input value, input bit_tick, output paused, output timer);
endinterface
`default_nettype wire

// file: logic/mdfc_pause_timer.sv
// Receive-side pause timer counted in 512 bit-time quanta
`timescale 1ns/10ps
`default_nettype none
module mdfc_pause_timer
  import mdfc_pkg::*;
#(
  parameter int QBITS = QUANTUM_BITS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Controller side
  mdfc_pause_if.tmr pif
);
  localparam int TW = $clog2(QBITS);

  // Quantum counter wraps on all ones, so only powers of two serve
  if (QBITS < 2 || (1 << TW) != QBITS) begin : g_bad_qbits
    $error("QBITS must be a power of two");
  end

  logic [TW-1:0] tick_q;
  logic [15:0] timer_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_q <= '0;
    end else if (pif.load) begin
      tick_q <= '0;
    end else if (pif.bit_tick) begin
      tick_q <= tick_q + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_q <= 16'h0000;
    end else if (pif.load) begin
      timer_q <= pif.value;
    end else if (pif.bit_tick && (&tick_q) && timer_q != 16'h0000) begin
      // one step per 512 bit times
      timer_q <= timer_q - 16'h0001;
    end
  end

  assign pif.timer = timer_q;
  assign pif.paused = (timer_q != 16'h0000);

  a_pause_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    pif.load |=> timer_q == $past(pif.value))
    else $error("pause timer not reloaded");
  a_quantum_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!pif.load && pif.bit_tick && !(&tick_q)) |=> $stable(timer_q))
    else $error("pause timer stepped early");
endmodule
`default_nettype wire

// file: verif/mdfc_remote_node.sv
// Remote station model: bit clock, byte and done pulses, collisions
`timescale 1ns/10ps
`default_nettype none
module mdfc_remote_node (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Bench settings
  input wire logic [7:0] i_col_at,
  input wire logic [7:0] i_len,
  // Medium
  input wire logic i_tx_en,
  output logic o_bit_tick,
  output logic o_tx_byte,
  output logic o_tx_done,
  output logic o_collision
);
  logic [2:0] bit_q;
  logic [7:0] byte_q;
  // Bit clock runs every cycle to keep slot times short
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bit_tick <= 1'b0;
      bit_q <= 3'h0;
      byte_q <= 8'h00;
      o_tx_byte <= 1'b0;
      o_tx_done <= 1'b0;
      o_collision <= 1'b0;
    end else begin
      o_bit_tick <= 1'b1;
      bit_q <= i_tx_en ? bit_q + 3'h1 : 3'h0;
      o_tx_byte <= i_tx_en && bit_q == 3'h7;
      o_tx_done <= i_tx_en && bit_q == 3'h7 && byte_q + 8'h01 == i_len;
      // Collide once, mid byte, when the wire reaches the set count
      o_collision <= i_tx_en && i_col_at != 8'h00 && byte_q == i_col_at && bit_q == 3'h3;
      if (!i_tx_en) begin
        byte_q <= 8'h00;
      end else if (bit_q == 3'h7) begin
        byte_q <= byte_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/mdfc_top_tb.sv
// Self-checking bench for the duplex and flow control block
`timescale 1ns/10ps
`default_nettype none
module mdfc_top_tb;
  import mdfc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mdfc_row_t;
  logic clk, rst, hsel, hwrite, hready, hresp, carrier, rx_pause, hit;
  logic tick, txb, done, col, tx_en, tx_err, lb, drv_off, rx_en;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] rx_val, tx_val;
  logic [7:0] col_at, len;
  mdfc_kind_t kind;
  int errors, checks;
  mdfc_row_t rows [13] = '{
    '{1'b0, OFS_CTRL, 32'h0, 32'h0}, '{1'b0, OFS_FLOW, 32'h0, 32'h0},
    '{1'b0, OFS_LIMIT, 32'h0, 32'h370F}, '{1'b0, OFS_GAP, 32'h0, 32'h12},
    '{1'b0, OFS_PAUSE, 32'h0, 32'h1000}, '{1'b0, OFS_STAT, 32'h0, 32'h0},
    '{1'b1, 8'h18, 32'hFFFFFFFF, 32'h0}, '{1'b1, OFS_GAP, 32'h5, 32'h5},
    '{1'b1, OFS_PAUSE, 32'hABCD, 32'hABCD}, '{1'b1, OFS_LIMIT, 32'h201, 32'h201},
    '{1'b1, OFS_CTRL, 32'hC, 32'hC}, '{1'b0, OFS_FLOW, 32'h0, 32'h4},
    '{1'b1, OFS_CTRL, 32'h0, 32'h0}};

  mdfc_top uut (.i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_bit_tick(tick), .i_carrier(carrier), .i_collision(col), .i_tx_byte(txb),
    .i_tx_done(done), .i_rx_pause(rx_pause), .i_rx_pause_val(rx_val), .i_rx_busy(1'b0),
    .o_tx_en(tx_en), .o_tx_kind(kind), .o_tx_pause_val(tx_val), .o_tx_err(tx_err),
    .o_loopback(lb), .o_tp_drv_off(drv_off), .o_rx_enable(rx_en));
  mdfc_remote_node peer (.i_sys_clk(clk), .i_rst(rst), .i_col_at(col_at), .i_len(len),
    .i_tx_en(tx_en), .o_bit_tick(tick), .o_tx_byte(txb), .o_tx_done(done),
    .o_collision(col));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      errors++;
      end_of_test;
    end
  endtask

  // Address phase held until ready, then data phase until ready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Bounded wait for transmit enable (s=0) or error pulse (s=1)
  task automatic wt(input int s, input logic v, input int lim);
    int n;
    n = 0;
    hit = 1'b0;
    while (n < lim && !hit) begin
      @(posedge clk);
      n++;
      hit = ((s == 0) ? tx_en : tx_err) === v;
    end
  endtask

  task automatic rxp(input logic [15:0] v);
    rx_val <= v;
    rx_pause <= 1'b1;
    @(posedge clk);
    rx_pause <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_of_test;
  end

  initial begin
    {rst, hsel, hwrite, carrier, rx_pause} = 5'b10000;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rx_val = 16'h0;
    col_at = 8'h00;
    len = 8'h08;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({tx_en, tx_err, drv_off, rx_en}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      rdm(rows[i].a, 32'hFFFFFFFF, rows[i].e);
    end
    chk(hresp, 1'b0);
    $display("register table done");
    // Half duplex send behind a busy medium
    carrier <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h1);
    wt(0, 1'b1, 60);
    chk(hit, 1'b0); // defer while carrier
    chk(lb, 1'b1); // default loopback
    carrier <= 1'b0;
    wt(0, 1'b1, 200);
    chk(hit, 1'b1); // half duplex sends
    chk(kind, KIND_PACKET); // packet kind
    wt(0, 1'b0, 200);
    chk(hit, 1'b1); // packet completes
    rdm(OFS_CTRL, 32'h1, 32'h0); // request cleared
    bus(1'b1, OFS_CTRL, 32'h10);
    repeat (2) @(posedge clk);
    chk(lb, 1'b0); // loopback disabled
    $display("half duplex send done");
    // Collision past the window aborts at once
    col_at <= 8'h04;
    bus(1'b1, OFS_CTRL, 32'h11);
    wt(1, 1'b1, 300);
    chk(hit, 1'b1); // late abort error
    rdm(OFS_STAT, 32'h9, 32'h9); // abort and late flags
    rdm(OFS_CTRL, 32'h1, 32'h0); // request cleared
    wt(0, 1'b1, 1200);
    chk(hit, 1'b0); // no retransmission
    bus(1'b1, OFS_STAT, 32'h1);
    $display("late collision done");
    // Early collision retries, then the retry limit aborts
    col_at <= 8'h01;
    bus(1'b1, OFS_CTRL, 32'h11);
    wt(0, 1'b1, 300);
    chk(hit, 1'b1); // first attempt sent
    wt(0, 1'b0, 100);
    chk(hit, 1'b1); // attempt cut by collision
    rdm(OFS_CTRL, 32'h1, 32'h1); // request stays set
    wt(0, 1'b1, 1500);
    chk(hit, 1'b1); // retransmitted after backoff
    wt(1, 1'b1, 300);
    chk(hit, 1'b1); // abort error pulse
    rdm(OFS_CTRL, 32'h1, 32'h0); // request cleared
    rdm(OFS_STAT, 32'h1, 32'h1); // abort flag
    bus(1'b1, OFS_STAT, 32'h1);
    $display("retry limit done");
    // jamming only on the closed bench medium
    col_at <= 8'h00;
    bus(1'b1, OFS_FLOW, 32'h1);
    wt(0, 1'b1, 50);
    chk(hit, 1'b1); // jam starts
    rdm(OFS_STAT, 32'h4, 32'h4); // jam flag
    bus(1'b1, OFS_CTRL, 32'h11);
    wt(0, 1'b0, 50);
    chk(hit, 1'b1); // jam stops for request
    wt(0, 1'b1, 100);
    chk(hit, 1'b1); // send after gap
    repeat (100) @(posedge clk);
    rdm(OFS_CTRL, 32'h1, 32'h0); // packet completed
    chk(tx_en, 1'b1); // jam resumed
    bus(1'b1, OFS_FLOW, 32'h0);
    wt(0, 1'b0, 50);
    chk(hit, 1'b1); // jam ends
    $display("jamming done");
    bus(1'b1, OFS_CTRL, 32'h8C);
    for (int m = 1; m < 4; m += 2) begin
      bus(1'b1, OFS_FLOW, 32'(m));
      wt(0, 1'b1, 100);
      chk(kind, KIND_PAUSE); // pause frame sent
      chk(tx_val, (m == 1) ? 16'hABCD : 16'h0); // pause value
      wt(0, 1'b0, 200);
      chk(hit, 1'b1); // pause frame completes
      rdm(OFS_FLOW, 32'h7, 32'h4); // turns itself off
    end
    bus(1'b1, OFS_PAUSE, 32'h4);
    bus(1'b1, OFS_FLOW, 32'h2);
    wt(0, 1'b1, 100);
    chk(hit, 1'b1); // periodic mode sends at once
    chk(tx_val, 16'h4); // programmed pause value
    wt(0, 1'b0, 200);
    chk(hit, 1'b1); // first periodic frame ends
    wt(0, 1'b1, 1500);
    chk(hit, 1'b1); // periodic resend
    wt(0, 1'b0, 200);
    chk(hit, 1'b1); // resent frame ends
    bus(1'b1, OFS_FLOW, 32'h0);
    chk(lb, 1'b0); // no default loopback
    bus(1'b1, OFS_CTRL, 32'h2C);
    repeat (2) @(posedge clk);
    chk({lb, drv_off}, 32'h3); // loopback kills driver
    col_at <= 8'h01;
    bus(1'b1, OFS_CTRL, 32'hD);
    wt(1, 1'b1, 150);
    chk(hit, 1'b0); // collisions ignored
    rdm(OFS_CTRL, 32'h1, 32'h0); // packet completed
    col_at <= 8'h00;
    $display("full duplex send done");
    // Received pause holds a request
    bus(1'b1, OFS_CTRL, 32'h4C);
    rxp(16'h2);
    bus(1'b1, OFS_CTRL, 32'h4F);
    wt(0, 1'b1, 900);
    chk(hit, 1'b0); // held while paused
    rdm(OFS_STAT, 32'h2, 32'h2); // paused flag
    chk(rx_en, 1'b1); // reception stays on
    wt(0, 1'b1, 300);
    chk(hit, 1'b1); // sent after two quanta
    wt(0, 1'b0, 200);
    chk(hit, 1'b1); // held packet completes
    rdm(OFS_CTRL, 32'h1, 32'h0); // request cleared
    rxp(16'h100);
    bus(1'b1, OFS_CTRL, 32'h4D);
    wt(0, 1'b1, 50);
    chk(hit, 1'b0); // long pause holds
    rxp(16'h0);
    wt(0, 1'b1, 50);
    chk(hit, 1'b1); // zero pause resumes
    wt(0, 1'b0, 200);
    chk(hit, 1'b1); // resumed packet completes
    $display("pause receive done");
    // Mismatched duplex bits never send
    bus(1'b1, OFS_CTRL, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h5);
    wt(0, 1'b1, 300);
    chk(hit, 1'b0); // mismatch blocks sending
    bus(1'b1, OFS_CTRL, 32'hC);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdm(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rdm(OFS_PAUSE, 32'hFFFFFFFF, 32'h1000);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
